// File: rcw_pkg.sv
// Package with register map, field layout and timing constants of the runaway code watchdog.
package rcw_pkg;
  // Register byte offsets.
  localparam logic [7:0] CONTROL_OFS = 8'h10;
  localparam logic [7:0] SERVICE_OFS = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  // Control field positions.
  localparam int ENABLE_BIT = 0;
  localparam int ACTION_BIT = 1;
  localparam int LOCK_BIT = 2;
  localparam int TIMEOUT_LSB = 8;
  localparam int COUNT_LSB = 16;
  localparam int FIELD_W = 7;
  // Reset value and service key.
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] SERVICE_KEY = 32'hC0DE_5AFE;
  // Prescaler: one count step is two to the twenty-first reference clocks.
  localparam int PRESCALE_BITS = 21;
  // Interrupt status bits: interrupt-action event and reset-action event.
  localparam int EVT_IRQ_BIT = 0;
  localparam int EVT_RST_BIT = 1;
  localparam int EVT_W = 2;
endpackage : rcw_pkg

// File: rcw_watchdog.sv
// Runaway code watchdog: prescaled timer, control, service key and interrupt logic.
// What this block does
// - Counter runs on reference oscillator clock.
// - Period is (timeout plus one) times 2^21.
// - Control bits 16-22 show running count.
// - Write lock blocks control writes until reset.
// - Action bit picks interrupt or system reset.
// - Enable bit starts and stops counting.
// - Timeout writes never reset the running counter.
// - Sleep freezes count, resumes on wake.
// - Key write restarts count from zero.
// - Key write clears pending watchdog interrupt while action bit selects interrupt.
// - Service register always reads the key.
// - Control, status and mask registers reset to zero, disabled, unprotected.
`timescale 1ns/10ps
`default_nettype none
module rcw_watchdog #(
  parameter int PRESCALE_BITS = rcw_pkg::PRESCALE_BITS // Prescaler width, shorten in simulation.
) (
  input wire logic sys_clk_in, // Reference oscillator clock, 24 MHz nominal.
  input wire logic rst_in, // Asynchronous reset, active high.
  input wire logic [7:0] addr_in, // Register byte address.
  input wire logic [31:0] wdata_in, // Write data.
  input wire logic wr_in, // Write strobe, one cycle.
  input wire logic rd_in, // Read strobe, one cycle.
  input wire logic sleep_in, // Core asleep, counting frozen (same clock domain).
  output logic [31:0] rdata_out, // Read data, valid the cycle after rd_in.
  output logic wdog_irq_out, // Watchdog interrupt request, level.
  output logic sys_reset_out, // System reset request, one-cycle pulse.
  output logic irq_out // Masked status interrupt, level.
);
  // Control state.
  logic enable_q; // Counting enabled.
  logic action_q; // One selects interrupt, zero selects system reset.
  logic lock_q; // Write protection.
  logic [rcw_pkg::FIELD_W-1:0] timeout_q; // Programmed time-out value.
  logic [rcw_pkg::FIELD_W-1:0] count_q; // Running count in coarse steps.
  logic [PRESCALE_BITS-1:0] pre_q; // Prescaler below the running count.
  logic [rcw_pkg::EVT_W-1:0] status_q; // Sticky event bits.
  logic [rcw_pkg::EVT_W-1:0] mask_q; // Interrupt mask bits.
  logic ctl_wr; // Control register write.
  logic key_wr; // Correct service key written.
  logic step; // Prescaler wraps this cycle.
  logic expire; // Time-out this cycle.
  logic [31:0] ctl_view; // Control register as read.
  logic [rcw_pkg::EVT_W-1:0] evt; // Events this cycle.

  // Decodes; a locked control write is dropped without any trace.
  // lock gates control writes
  assign ctl_wr = wr_in && (addr_in == rcw_pkg::CONTROL_OFS) && !lock_q;
  assign key_wr = wr_in && (addr_in == rcw_pkg::SERVICE_OFS) && (wdata_in == rcw_pkg::SERVICE_KEY);
  assign step = enable_q && !sleep_in && (&pre_q);
  assign expire = step && (count_q == timeout_q);
  assign evt = {expire && !action_q, expire && action_q};

  // Control fields; all clear at reset, so the block wakes disabled.
  // zero reset state
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_q <= 1'b0;
      action_q <= 1'b0;
      lock_q <= 1'b0;
      timeout_q <= '0;
    end else if (ctl_wr) begin
      enable_q <= wdata_in[rcw_pkg::ENABLE_BIT];
      action_q <= wdata_in[rcw_pkg::ACTION_BIT];
      lock_q <= wdata_in[rcw_pkg::LOCK_BIT];
      timeout_q <= wdata_in[rcw_pkg::TIMEOUT_LSB +: rcw_pkg::FIELD_W];
    end
  end

  // Prescaler and running count; a timeout write does not touch them, so a
  // change made while counting gives a first period off the programmed one.
  // reference clock counting
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_q <= '0;
      count_q <= '0;
    end else if (key_wr || expire) begin
      pre_q <= '0;
      count_q <= '0;
    end else if (enable_q && !sleep_in) begin
      pre_q <= pre_q + 1'b1;
      if (step) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // Time-out action: interrupt level held until serviced, or reset pulse.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdog_irq_out <= 1'b0;
      sys_reset_out <= 1'b0;
    end else begin
      sys_reset_out <= evt[rcw_pkg::EVT_RST_BIT];
      // A time-out in the same cycle as the key wins over the clear.
      if (evt[rcw_pkg::EVT_IRQ_BIT]) begin
        wdog_irq_out <= 1'b1;
      end else if (key_wr && action_q) begin
        wdog_irq_out <= 1'b0;
      end
    end
  end

  // Sticky status, write one to clear; a new event beats the clear.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr_in && addr_in == rcw_pkg::IRQ_STATUS_OFS) begin
        status_q <= (status_q & ~wdata_in[rcw_pkg::EVT_W-1:0]) | evt;
      end else begin
        status_q <= status_q | evt;
      end
      if (wr_in && addr_in == rcw_pkg::IRQ_MASK_OFS) begin
        mask_q <= wdata_in[rcw_pkg::EVT_W-1:0];
      end
    end
  end

  // Interrupt output is registered from the next status and mask values.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((status_q | evt) & ~((wr_in && addr_in == rcw_pkg::IRQ_STATUS_OFS) ?
                 wdata_in[rcw_pkg::EVT_W-1:0] & ~evt : '0)) &
                 ((wr_in && addr_in == rcw_pkg::IRQ_MASK_OFS) ?
                 wdata_in[rcw_pkg::EVT_W-1:0] : mask_q));
    end
  end

  // Control view with reserved bits at zero.
  // count read-only view
  always_comb begin
    ctl_view = rcw_pkg::CONTROL_RST;
    ctl_view[rcw_pkg::ENABLE_BIT] = enable_q;
    ctl_view[rcw_pkg::ACTION_BIT] = action_q;
    ctl_view[rcw_pkg::LOCK_BIT] = lock_q;
    ctl_view[rcw_pkg::TIMEOUT_LSB +: rcw_pkg::FIELD_W] = timeout_q;
    ctl_view[rcw_pkg::COUNT_LSB +: rcw_pkg::FIELD_W] = count_q;
  end

  // Read data stands only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      unique case (addr_in)
        rcw_pkg::CONTROL_OFS: rdata_out <= ctl_view;
        rcw_pkg::SERVICE_OFS: rdata_out <= rcw_pkg::SERVICE_KEY;
        rcw_pkg::IRQ_STATUS_OFS: rdata_out <= {30'h0000_0000, status_q};
        rcw_pkg::IRQ_MASK_OFS: rdata_out <= {30'h0000_0000, mask_q};
        default: rdata_out <= '0;
      endcase
    end else begin
      rdata_out <= '0;
    end
  end

  // Named steps of the service and time-out behaviour, shared by the properties below.
  sequence s_key_write;
    key_wr;
  endsequence

  // A time-out seen on the decode, before any action is registered.
  sequence s_timeout;
    expire;
  endsequence

  // Both counter stages back at zero, as after a restart.
  sequence s_restarted;
    (count_q == '0) && (pre_q == '0);
  endsequence

  a_lock_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lock_q |=> lock_q) else $error("write lock dropped without reset");
  a_enable_locked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lock_q |=> $stable(enable_q)) else $error("enable changed while locked");
  a_key_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_key_write |=> (count_q == '0 && pre_q == '0)) else $error("key did not restart count");
  a_key_clears_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (s_key_write and (action_q && !expire)) |=> !wdog_irq_out) else $error("irq kept after key");
  a_timeout_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (expire && action_q) |=> (wdog_irq_out && !sys_reset_out)) else $error("irq action missed");
  a_timeout_reset: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (expire && !action_q) |=> sys_reset_out) else $error("reset action missed");
  a_count_bound: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (enable_q && count_q == timeout_q && step) |=> count_q == '0) else $error("count overran");
  a_sleep_frozen: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sleep_in && !key_wr && !ctl_wr) |=> $stable(count_q) && $stable(pre_q))
    else $error("count moved in sleep");
  a_service_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (rd_in && addr_in == rcw_pkg::SERVICE_OFS) |=> rdata_out == rcw_pkg::SERVICE_KEY)
    else $error("service read wrong");
  a_bad_key: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr_in && addr_in == rcw_pkg::SERVICE_OFS && !key_wr && !enable_q && !expire) |=>
    $stable(count_q) && $stable(wdog_irq_out)) else $error("wrong key had effect");
  a_timeout_kept: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ctl_wr && step && !expire && !key_wr) |=> count_q == $past(count_q) + 1'b1)
    else $error("timeout write reset count");

  // The checks below watch the counter, the control fields, the action outputs, the status logging and the read path.
  // They are kept apart from the logic so a broken datapath cannot hide in them.

  a_expire_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_timeout |=> s_restarted)
    else $error("count not restarted after time-out");

  a_action_cause: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (sys_reset_out || $rose(wdog_irq_out)) |-> $past(expire))
    else $error("action without time-out");

  a_reset_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_reset_out |=> !sys_reset_out)
    else $error("reset pulse too long");

  a_reset_select: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_reset_out |-> !$past(action_q))
    else $error("reset raised with interrupt action");

  a_irq_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wdog_irq_out && !key_wr) |=> wdog_irq_out)
    else $error("request dropped without key");

  a_bad_key_irq: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr_in && addr_in == rcw_pkg::SERVICE_OFS && !key_wr && !expire) |=> $stable(wdog_irq_out))
    else $error("wrong key moved request");

  a_disabled_frozen: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!enable_q && !key_wr) |=> $stable(count_q) && $stable(pre_q))
    else $error("count moved while disabled");

  a_ctl_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ctl_wr |=> (enable_q == $past(wdata_in[rcw_pkg::ENABLE_BIT])) &&
    (action_q == $past(wdata_in[rcw_pkg::ACTION_BIT])))
    else $error("control write lost");

  a_lock_blocks: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (wr_in && addr_in == rcw_pkg::CONTROL_OFS && lock_q) |=>
    $stable(timeout_q) && $stable(action_q))
    else $error("locked control changed");

  a_pre_runs: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (enable_q && !sleep_in && !key_wr && !expire) |=> pre_q == $past(pre_q) + 1'b1)
    else $error("prescaler stalled");

  a_step_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (step && !expire && !key_wr) |=> count_q == $past(count_q) + 1'b1)
    else $error("count missed a step");

  a_write_keeps: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (ctl_wr && !key_wr && !expire) |=>
    (count_q == $past(count_q)) || (count_q == $past(count_q) + 1'b1))
    else $error("control write disturbed count");

  a_count_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (rd_in && addr_in == rcw_pkg::CONTROL_OFS) |=> rdata_out[22:16] == $past(count_q))
    else $error("count view wrong");

  a_ctl_reserved: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (rd_in && addr_in == rcw_pkg::CONTROL_OFS) |=>
    (rdata_out[31:23] == '0) && (rdata_out[15] == 1'b0) && (rdata_out[7:3] == '0))
    else $error("reserved control bits set");

  a_rdata_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rd_in |=> rdata_out == '0)
    else $error("read data outside read cycle");

  a_status_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_timeout |=> status_q != '0)
    else $error("time-out not logged");

  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_out == |(status_q & mask_q))
    else $error("status interrupt level wrong");
endmodule : rcw_watchdog
`default_nettype wire

// File: runaway_code_watchdog_tb_top.sv
// Self-checking testbench of the runaway code watchdog.
`timescale 1ns/10ps
`default_nettype none
module runaway_code_watchdog_tb_top;
  localparam int PB = 2; // Short prescaler: four clocks per count step.
  logic sys_clk_in = 1'b0; // Reference clock, 100 ns period.
  logic rst_in = 1'b1; // Reset, active high.
  logic [7:0] addr_in = 8'h00; // Register address.
  logic [31:0] wdata_in = 32'h0000_0000; // Write data.
  logic wr_in = 1'b0; // Write strobe.
  logic rd_in = 1'b0; // Read strobe.
  logic sleep_in = 1'b0; // Sleep freeze.
  logic [31:0] rdata_out; // Read data.
  logic wdog_irq_out, sys_reset_out, irq_out; // Time-out and status outputs.
  int n_errors = 0; // Mismatch count.
  int n_checks = 0; // Comparison count.
  logic [31:0] seed = 32'h27DFFEE7; // Fixed random seed.
  logic [6:0] t; // Drawn time-out value.
  // Free running clock.
  always #50 sys_clk_in = ~sys_clk_in;
  rcw_watchdog #(.PRESCALE_BITS(PB)) rcw_watchdog_inst (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .sleep_in(sleep_in), .rdata_out(rdata_out), .wdog_irq_out(wdog_irq_out),
    .sys_reset_out(sys_reset_out), .irq_out(irq_out));
  // Xorshift generator keeps the run repeatable.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs
  // Control word built from its fields.
  function automatic logic [31:0] ctl(input logic [6:0] v, input logic a, l, e);
    return {17'h00000, v, 5'h00, l, a, e};
  endfunction : ctl
  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  // A write leaves one idle cycle so a strobe is never assigned twice in a time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    tick(1);
    wr_in <= 1'b0;
    tick(1);
  endtask : wr
  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    addr_in <= a;
    rd_in <= 1'b1;
    tick(1);
    rd_in <= 1'b0;
    chk(nm, e, rdata_out);
    tick(1);
  endtask : rd
  // The output must stay low one edge before the period ends and rise exactly at its end.
  task automatic expire(input logic [6:0] v, input int skip, input bit sel);
    tick((v + 1) * (2 ** PB) - skip - 1);
    chk("early", 32'(1'b0), 32'(sel ? sys_reset_out : wdog_irq_out));
    tick(1);
    chk("fire", 32'(1'b1), 32'(sel ? sys_reset_out : wdog_irq_out));
  endtask : expire
  // A hang ends the run as a failure.
  initial begin
    #5000000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    tick(1);
    rd(rcw_pkg::CONTROL_OFS, rcw_pkg::CONTROL_RST, "control");
    rd(rcw_pkg::SERVICE_OFS, rcw_pkg::SERVICE_KEY, "service");
    rd(8'h30, 32'h0000_0000, "unmapped");
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      t = {4'h0, seed[2:0]};
      // Program while disabled, zero the count, then enable.
      wr(rcw_pkg::CONTROL_OFS, ctl(t, k < 3, 1'b0, 1'b0));
      wr(rcw_pkg::SERVICE_OFS, rcw_pkg::SERVICE_KEY);
      wr(rcw_pkg::CONTROL_OFS, ctl(t, k < 3, 1'b0, 1'b1));
      expire(t, 1, k == 3);
      wr(rcw_pkg::CONTROL_OFS, ctl(t, k < 3, 1'b0, 1'b0));
      if (k == 3) begin
        chk("rst_pulse", 32'h0, 32'(sys_reset_out));
        rd(rcw_pkg::IRQ_STATUS_OFS, 32'h0000_0002, "status");
      end else begin
        rd(rcw_pkg::IRQ_STATUS_OFS, 32'h0000_0001, "status");
        chk("irq_masked", 32'h0, 32'(irq_out));
        wr(rcw_pkg::IRQ_MASK_OFS, 32'h0000_0001);
        chk("irq_on", 32'h1, 32'(irq_out));
        wr(rcw_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
        chk("irq_clr", 32'h0, 32'(irq_out));
        wr(rcw_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        seed = xs(seed);
        wr(rcw_pkg::SERVICE_OFS, rcw_pkg::SERVICE_KEY ^ (seed | 32'h1));
        chk("bad_key", 32'h1, 32'(wdog_irq_out));
        wr(rcw_pkg::SERVICE_OFS, rcw_pkg::SERVICE_KEY);
        chk("key_clr", 32'h0, 32'(wdog_irq_out));
        // Restart from zero, with a sleep spell that must only freeze the count.
        wr(rcw_pkg::CONTROL_OFS, ctl(t, 1'b1, 1'b0, 1'b1));
        sleep_in <= 1'b1;
        tick(5);
        sleep_in <= 1'b0;
        expire(t, 1, 1'b0);
        wr(rcw_pkg::SERVICE_OFS, rcw_pkg::SERVICE_KEY);
        // The second expiry logged again; clear it so the next pass starts clean.
        wr(rcw_pkg::IRQ_STATUS_OFS, 32'h0000_0001);
        rd(rcw_pkg::IRQ_STATUS_OFS, 32'h0000_0000, "status_clr");
      end
    end
    // Locked control: running count visible, further writes ignored.
    wr(rcw_pkg::SERVICE_OFS, rcw_pkg::SERVICE_KEY);
    wr(rcw_pkg::CONTROL_OFS, ctl(7'h07, 1'b0, 1'b1, 1'b1));
    tick(11);
    rd(rcw_pkg::CONTROL_OFS, 32'h0003_0705, "count");
    wr(rcw_pkg::CONTROL_OFS, 32'h0000_0000);
    rd(rcw_pkg::CONTROL_OFS, 32'h0004_0705, "locked");
    // A reset in mid-run clears the lock and all fields.
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    tick(1);
    rd(rcw_pkg::CONTROL_OFS, rcw_pkg::CONTROL_RST, "control2");
    summarize();
  end
endmodule : runaway_code_watchdog_tb_top
`default_nettype wire
